// ### pwc_regs.svh
/*
  Timing constants for the host-side controller of an 8K x 8 parallel EEPROM.
  Assumes a 40 MHz system clock; every count is a time divided by the clock period.
*/
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH
`define PWC_CLK_PERIOD_PS      25000
`define PWC_ADDR_W             13
`define PWC_DATA_W             8
`define PWC_PAGE_LSB           5
`define PWC_PAGE_BYTES         32
`define PWC_POLL_BIT           7
`define PWC_ACCESS_NS          150
`define PWC_ACCESS_CYC         ((`PWC_ACCESS_NS * 1000 + `PWC_CLK_PERIOD_PS - 1) / `PWC_CLK_PERIOD_PS)
`define PWC_WP_NS              110
`define PWC_WP_CYC             ((`PWC_WP_NS * 1000 + `PWC_CLK_PERIOD_PS - 1) / `PWC_CLK_PERIOD_PS)
`define PWC_HZ_NS              50
`define PWC_HZ_CYC             ((`PWC_HZ_NS * 1000 + `PWC_CLK_PERIOD_PS - 1) / `PWC_CLK_PERIOD_PS)
`define PWC_BLC_MIN_NS         50
`define PWC_BLC_MIN_CYC        ((`PWC_BLC_MIN_NS * 1000 + `PWC_CLK_PERIOD_PS - 1) / `PWC_CLK_PERIOD_PS)
`define PWC_BLC_MAX_US         100
`define PWC_BLC_MAX_CYC        ((`PWC_BLC_MAX_US * 1000000) / `PWC_CLK_PERIOD_PS)
`define PWC_INIT_MAX_MS        10
`define PWC_INIT_CYC           ((`PWC_INIT_MAX_MS * 1000000) / (`PWC_CLK_PERIOD_PS / 1000))
`define PWC_WC_MAX_MS          5
`define PWC_WC_CYC             ((`PWC_WC_MAX_MS * 1000000) / (`PWC_CLK_PERIOD_PS / 1000))
`endif

// ### pwc_pkg.sv
/*
  Types for the host-side parallel EEPROM controller.
  Assumes pwc_regs.svh supplies the widths.
*/
`include "pwc_regs.svh"
package pwc_pkg;
  typedef logic [`PWC_ADDR_W-1:0] pwc_addr_type;
  typedef logic [`PWC_DATA_W-1:0] pwc_data_type;
  typedef enum logic [3:0] {
    PWC_INIT  = 4'h0,
    PWC_IDLE  = 4'h1,
    PWC_RD    = 4'h3,
    PWC_RDHZ  = 4'h2,
    PWC_WLOW  = 4'h6,
    PWC_WHIGH = 4'h7,
    PWC_WAIT  = 4'h5,
    PWC_POLL  = 4'h4,
    PWC_PHZ   = 4'hc
  } pwc_state_type;
endpackage

// ### pwc_tmr_if.sv
/*
  Interface between the controller and its interval timer.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface pwc_tmr_if;
  logic        load;
  logic [31:0] count;
  logic        done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// ### pwc_timer.sv
/*
  Down-counting interval timer used for strobe, access, float and power-up timing; the load window and program budget count in wait_ff.
  Assumes load is a one-cycle pulse with the cycle count to wait.
*/
`timescale 1ns/1ps
module pwc_timer (
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  pwc_tmr_if.tmr    tmr
);
  logic [31:0] cnt_ff;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt_ff <= 32'h0;
    end else if (tmr.load) begin
      cnt_ff <= tmr.count;
    end else if (cnt_ff != 32'h0) begin
      cnt_ff <= cnt_ff - 32'h1;
    end
  end

  assign tmr.done = (cnt_ff == 32'h0);
endmodule

// ### pwc_ctrl.sv
/*
  Host controller that drives an 8K x 8 parallel EEPROM through its pins.
  Assumes the memory pins are synchronous to clk_sys_in and the data bus is
  resolved outside from the output enable.
*/
`timescale 1ns/1ps
`include "pwc_regs.svh"
module pwc_ctrl
  import pwc_pkg::*;
#(
  parameter int unsigned INIT_CYC = `PWC_INIT_CYC,
  parameter int unsigned WC_CYC   = `PWC_WC_CYC,
  parameter int unsigned BLC_CYC  = `PWC_BLC_MAX_CYC
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire logic             req_valid_in,
  input  wire logic             req_write_in,
  input  wire logic             req_last_in,
  input  wire pwc_pkg::pwc_addr_type req_addr_in,
  input  wire pwc_pkg::pwc_data_type req_wdata_in,
  output logic                  req_ready_out,
  output logic                  rd_valid_out,
  output pwc_pkg::pwc_data_type rd_data_out,
  output logic                  wr_done_out,
  output logic                  busy_out,
  output logic                  mem_ce_n_out,
  output logic                  mem_we_n_out,
  output logic                  mem_oe_n_out,
  output pwc_pkg::pwc_addr_type mem_addr_out,
  output pwc_pkg::pwc_data_type mem_data_out,
  output logic                  mem_data_oe_out,
  input  wire pwc_pkg::pwc_data_type mem_data_in
);
  import pwc_pkg::*;

  localparam logic [31:0] WP_CYC  = 32'(`PWC_WP_CYC);
  localparam logic [31:0] ACC_CYC = 32'(`PWC_ACCESS_CYC);
  localparam logic [31:0] HZ_CYC  = 32'(`PWC_HZ_CYC);
  localparam logic [31:0] BMIN    = 32'(`PWC_BLC_MIN_CYC);

  pwc_state_type state_ff;
  pwc_state_type nxt_state;
  pwc_addr_type  addr_ff;
  pwc_data_type  wdata_ff;
  pwc_data_type  rdata_ff;
  pwc_data_type  last_data_ff;
  pwc_addr_type  last_addr_ff;
  logic [`PWC_ADDR_W-`PWC_PAGE_LSB-1:0] page_ff;
  logic          page_open_ff;
  logic          last_ff;
  logic          rd_valid_ff;
  logic          wr_done_ff;
  logic          lockout_ff;
  logic [31:0]   wait_ff;

  pwc_tmr_if tif ();

  pwc_timer pwc_timer_inst (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .tmr        (tif)
  );

  // A load is accepted only while idle, after lockout, and within the open page.
  assign req_ready_out = (state_ff == PWC_IDLE) && !lockout_ff && tif.done &&
                         (!req_write_in || !page_open_ff ||
                          req_addr_in[`PWC_ADDR_W-1:`PWC_PAGE_LSB] == page_ff);
  wire take = req_valid_in && req_ready_out;

  // Sequencer for read, byte-load and completion polling.
  always_comb begin
    nxt_state = state_ff;
    tif.load  = 1'b0;
    tif.count = 32'h0;
    unique case (state_ff)
      PWC_INIT: begin
        if (lockout_ff && wait_ff == 32'(INIT_CYC)) begin
          tif.load  = 1'b1;
          tif.count = 32'(INIT_CYC);
        end else if (tif.done) begin
          nxt_state = PWC_IDLE;
        end
      end
      PWC_IDLE: begin
        if (take) begin
          tif.load  = 1'b1;
          tif.count = req_write_in ? WP_CYC : ACC_CYC;
          nxt_state = req_write_in ? PWC_WLOW : PWC_RD;
        end else if (page_open_ff && wait_ff == 32'h0) begin
          tif.load  = 1'b1;
          tif.count = HZ_CYC;
          nxt_state = PWC_WAIT;
        end
      end
      PWC_RD: begin
        if (tif.done) begin
          tif.load  = 1'b1;
          tif.count = HZ_CYC;
          nxt_state = PWC_RDHZ;
        end
      end
      PWC_RDHZ: begin
        if (tif.done) begin
          nxt_state = PWC_IDLE;
        end
      end
      PWC_WLOW: begin
        if (tif.done) begin
          tif.load  = 1'b1;
          tif.count = BMIN;
          nxt_state = PWC_WHIGH;
        end
      end
      PWC_WHIGH: begin
        if (tif.done) begin
          nxt_state = PWC_IDLE;
        end
      end
      PWC_WAIT: begin
        if (tif.done) begin
          tif.load  = 1'b1;
          tif.count = ACC_CYC;
          nxt_state = PWC_POLL;
        end
      end
      PWC_POLL: begin
        if (tif.done) begin
          tif.load  = 1'b1;
          tif.count = HZ_CYC;
          nxt_state = PWC_PHZ;
        end
      end
      PWC_PHZ: begin
        if (tif.done) begin
          nxt_state = (rdata_ff[`PWC_POLL_BIT] == last_data_ff[`PWC_POLL_BIT] ||
                       wait_ff == 32'h0) ? PWC_IDLE : PWC_WAIT;
          if (nxt_state == PWC_WAIT) begin
            tif.load  = 1'b1;
            tif.count = HZ_CYC;
          end
        end
      end
      default: begin
        nxt_state = PWC_INIT;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_ff <= PWC_INIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Lockout flag clears once the power-up wait has run out.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      lockout_ff <= 1'b1;
    end else if (state_ff == PWC_INIT && tif.done && !tif.load) begin
      lockout_ff <= 1'b0;
    end
  end

  // Window counter: load window while a page is open, program budget while polling.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wait_ff <= 32'(INIT_CYC);
    end else if (state_ff == PWC_INIT) begin
      wait_ff <= 32'h0;
    end else if (state_ff == PWC_WHIGH && nxt_state == PWC_IDLE) begin
      wait_ff <= last_ff ? 32'h0 : 32'(BLC_CYC) - 32'(`PWC_BLC_MIN_CYC);
    end else if (state_ff == PWC_IDLE && nxt_state == PWC_WAIT) begin
      wait_ff <= 32'(WC_CYC) + 32'(BLC_CYC);
    end else if (wait_ff != 32'h0 && state_ff != PWC_WLOW) begin
      wait_ff <= wait_ff - 32'h1;
    end
  end

  // Latches the accepted request and tracks the open page.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      addr_ff      <= '0;
      wdata_ff     <= '0;
      last_addr_ff <= '0;
      last_data_ff <= '0;
      page_ff      <= '0;
      page_open_ff <= 1'b0;
      last_ff      <= 1'b0;
    end else if (take) begin
      addr_ff  <= req_addr_in;
      wdata_ff <= req_wdata_in;
      if (req_write_in) begin
        last_addr_ff <= req_addr_in;
        last_data_ff <= req_wdata_in;
        page_ff      <= req_addr_in[`PWC_ADDR_W-1:`PWC_PAGE_LSB];
        page_open_ff <= 1'b1;
        last_ff      <= req_last_in;
      end
    end else if (nxt_state == PWC_WAIT && state_ff == PWC_IDLE) begin
      page_open_ff <= 1'b0;
      addr_ff      <= last_addr_ff;
    end
  end

  // Captures read data at the end of the access time.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rdata_ff    <= '0;
      rd_valid_ff <= 1'b0;
      wr_done_ff  <= 1'b0;
    end else begin
      rd_valid_ff <= state_ff == PWC_RD && tif.done;
      wr_done_ff  <= state_ff == PWC_PHZ && nxt_state == PWC_IDLE;
      if ((state_ff == PWC_RD || state_ff == PWC_POLL) && tif.done) begin
        rdata_ff <= mem_data_in;
      end
    end
  end

  assign rd_valid_out    = rd_valid_ff;
  assign rd_data_out     = rdata_ff;
  assign wr_done_out     = wr_done_ff;
  assign busy_out        = !(state_ff == PWC_IDLE) || page_open_ff;
  assign mem_addr_out    = addr_ff;
  assign mem_data_out    = wdata_ff;
  assign mem_ce_n_out    = !(state_ff == PWC_RD || state_ff == PWC_WLOW || state_ff == PWC_POLL);
  assign mem_we_n_out    = !(state_ff == PWC_WLOW);
  assign mem_oe_n_out    = !(state_ff == PWC_RD || state_ff == PWC_POLL);
  assign mem_data_oe_out = state_ff == PWC_WLOW || state_ff == PWC_WHIGH;

  a_write_strobe_ok: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !mem_we_n_out |-> !mem_ce_n_out && mem_oe_n_out)
    else $error("Write strobe low without select or with output drive low.");
  a_no_read_contend: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !mem_oe_n_out |-> !mem_data_oe_out && mem_we_n_out)
    else $error("Host drives data while memory output enabled.");
  a_pulse_width: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $fell(mem_we_n_out) |-> !mem_we_n_out [*5])
    else $error("Write strobe pulse too short.");
  a_lockout_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    lockout_ff |-> mem_we_n_out)
    else $error("Write strobe during power-up lockout.");
  a_page_same: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $fell(mem_we_n_out) && $past(page_open_ff) |->
      mem_addr_out[`PWC_ADDR_W-1:`PWC_PAGE_LSB] == $past(page_ff))
    else $error("Load crosses page boundary.");
  a_no_load_busy: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_ff == PWC_POLL |-> mem_we_n_out && !req_ready_out)
    else $error("Load accepted during programming.");
  sequence s_strobe_rise;
    $rose(mem_we_n_out);
  endsequence
  sequence s_strobe_rest;
    mem_we_n_out [*2];
  endsequence
  a_recovery_gap: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_strobe_rise |-> s_strobe_rest)
    else $error("Byte loads spaced too closely.");
  a_poll_addr: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_ff == PWC_POLL |-> mem_addr_out == last_addr_ff)
    else $error("Polling read not at last written address.");
endmodule

// ### pwc_mem_model.sv
/*
  Behavioural model of the 8K x 8 parallel memory on the pins of pwc_ctrl.
  Assumes the strobes come from logic on clk_sys_in; its timers count that clock.
*/
`timescale 1ns/1ps
module pwc_mem_model #(
  parameter int LOCK_CYC = 15,
  parameter int BLC_CYC  = 10
) (
  input  wire logic        clk_sys_in,
  input  wire logic        ce_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic [12:0] addr_in,
  input  wire logic [7:0]  data_in,
  input  wire logic [7:0]  prog_cyc_in,
  output logic      [7:0]  dq_out,
  output logic             dq_oe_out
);
  logic [7:0]  mem [8192];
  logic [7:0]  pbuf [32];
  logic [31:0] pval = '0;
  logic [12:0] a_lat;
  logic [12:0] last_a = '0;
  logic [7:0]  last_d = '0;
  logic [7:0]  noise = '0;
  logic [7:0]  pg = '0;
  int          lock_cnt = 0;
  int          blc_cnt = 0;
  int          prog_cnt = 0;
  bit          open = 0;
  realtime     t_low;
  wire         w_act = !ce_n_in && !we_n_in && oe_n_in;
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 5);
    end
  end
  always @(posedge w_act) begin
    t_low = $realtime;
    #1;
    a_lat = addr_in;
  end
  always @(negedge w_act) begin
    if ($realtime - t_low >= 20.0 && prog_cnt == 0 && lock_cnt >= LOCK_CYC) begin
      if (!open) pval = '0;
      pbuf[a_lat[4:0]] = data_in;
      pval[a_lat[4:0]] = 1'b1;
      pg = a_lat[12:5];
      last_a = a_lat;
      last_d = data_in;
      open = 1;
      blc_cnt = 0;
    end
  end
  always @(posedge clk_sys_in) begin
    noise = noise + 8'h35;
    if (lock_cnt < LOCK_CYC) lock_cnt = lock_cnt + 1;
    if (open && we_n_in) begin
      blc_cnt = blc_cnt + 1;
      if (blc_cnt >= BLC_CYC) begin
        open = 0;
        prog_cnt = prog_cyc_in;
      end
    end else if (prog_cnt == 1) begin
      for (int i = 0; i < 32; i++) begin
        if (pval[i]) mem[{pg, 5'(i)}] = pbuf[i];
      end
      prog_cnt = 0;
    end else if (prog_cnt > 1) prog_cnt = prog_cnt - 1;
  end
  always @* begin
    dq_oe_out = !ce_n_in && !oe_n_in && we_n_in;
    if (open || prog_cnt != 0) dq_out = (addr_in == last_a) ? {~last_d[7], noise[6:0]} : noise;
    else dq_out = mem[addr_in];
  end
endmodule

// ### pwc_ctrl_bench.sv
/*
  Self-checking bench for pwc_ctrl driving the behavioural memory model.
  Assumes shortened lockout, program and load-window counts set below.
*/
`timescale 1ns/1ps
module pwc_ctrl_bench;
  import pwc_pkg::*;
  logic         clk_sys_in = 0;
  logic         rst_in = 1;
  logic         valid = 0;
  logic         wr = 0;
  logic         last = 0;
  pwc_addr_type addr = '0;
  pwc_addr_type maddr;
  pwc_data_type wdata = '0;
  pwc_data_type rd_data, dq, dout;
  pwc_data_type bus_q = '0;
  logic         ready, rd_valid, wr_done, busy, ce_n, we_n, oe_n, d_oe, dq_oe;
  logic [7:0]   prog_cyc = 8'h1e;
  logic [31:0]  lfsr = 32'h7fa1;
  logic [7:0]   shadow [8192];
  int           err_total = 0;
  int           n_compared = 0;
  int           done_cnt = 0;
  int           done_exp = 0;
  wire  [7:0]   bus = d_oe ? dout : dq_oe ? dq : ~bus_q;
  always #12.5 clk_sys_in = ~clk_sys_in;
  pwc_ctrl #(.INIT_CYC(20), .WC_CYC(50), .BLC_CYC(10)) pwc_ctrl_inst (
    .clk_sys_in, .rst_in, .req_valid_in(valid), .req_write_in(wr), .req_last_in(last),
    .req_addr_in(addr), .req_wdata_in(wdata), .req_ready_out(ready),
    .rd_valid_out(rd_valid), .rd_data_out(rd_data), .wr_done_out(wr_done),
    .busy_out(busy), .mem_ce_n_out(ce_n), .mem_we_n_out(we_n), .mem_oe_n_out(oe_n),
    .mem_addr_out(maddr), .mem_data_out(dout), .mem_data_oe_out(d_oe), .mem_data_in(bus));
  pwc_mem_model #(.LOCK_CYC(15), .BLC_CYC(10)) pwc_mem_model_inst (
    .clk_sys_in, .ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n), .addr_in(maddr),
    .data_in(bus), .prog_cyc_in(prog_cyc), .dq_out(dq), .dq_oe_out(dq_oe));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic req(input logic w, input logic l, input pwc_addr_type a, input pwc_data_type d);
    int n;
    n = 0;
    @(negedge clk_sys_in);
    valid = 1;
    wr = w;
    last = l;
    addr = a;
    wdata = d;
    #1;
    while (ready !== 1'b1 && n < 400) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(n < 400, 1);
    @(negedge clk_sys_in);
    valid = 0;
    if (w) shadow[a] = d;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    done_exp++;
    chk(busy, 1);
    while (done_cnt < done_exp && n < 120) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(n < 120, 1);
    chk(done_cnt, done_exp);
  endtask
  task automatic rd(input pwc_addr_type a);
    int n;
    n = 0;
    req(0, 0, a, 8'h00);
    while (rd_valid !== 1'b1 && n < 20) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(rd_valid, 1);
    chk(rd_data, shadow[a]);
  endtask
  task automatic page(input logic [7:0] pg, input int cnt, input logic close);
    logic [4:0] pos;
    pos = lfsr[4:0];
    for (int i = 0; i < cnt; i++) begin
      lfsr = nxt(lfsr);
      req(1, close && (i == cnt - 1), {pg, pos + 5'(i * 7)}, lfsr[15:8]);
    end
    wait_done();
    for (int i = 0; i < 32; i++) rd({pg, 5'(i)});
  endtask
  always @(negedge clk_sys_in) begin
    if (!rst_in) begin
      chk(d_oe & dq_oe, 0);
      chk(!ce_n & !we_n & !oe_n, 0);
    end
  end
  always @(posedge clk_sys_in) begin
    bus_q <= bus;
  end
  always @(negedge clk_sys_in) begin
    if (wr_done === 1'b1) done_cnt++;
  end
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    err_total++;
    tally_and_finish();
  end
  initial begin
    for (int i = 0; i < 8192; i++) shadow[i] = 8'(i) ^ 8'(i >> 5);
    repeat (16) @(negedge clk_sys_in);
    chk(ce_n & we_n & oe_n, 1);
    rst_in = 0;
    repeat (18) begin
      @(negedge clk_sys_in);
      chk(ready, 0);
    end
    rd(13'h0000);
    rd(13'h1fff);
    req(1, 1, 13'h1fff, 8'h80);
    wait_done();
    rd(13'h1fff);
    page(8'h00, 32, 1);
    prog_cyc = 8'h28;
    page(8'hff, 1, 1);
    page(8'h5a, 5, 0);
    req(1, 0, 13'h0b43, 8'h3c);
    req(1, 1, 13'h0c00, 8'hc3);
    wait_done();
    wait_done();
    rd(13'h0b43);
    rd(13'h0c00);
    for (int k = 0; k < 30; k++) begin
      lfsr = nxt(lfsr);
      prog_cyc = lfsr[24] ? 8'h28 : 8'h0c;
      if (lfsr[0]) begin
        req(1, 1, lfsr[20:8], lfsr[31:24]);
        wait_done();
      end
      rd(lfsr[20:8]);
    end
    tally_and_finish();
  end
endmodule
